// file: verilog/lbc_pkg.sv
`default_nettype none
package lbc_pkg;
	// Width of every management register and of both result counters.
	localparam int unsigned      REG_W          = 8;
	// Management register addresses.
	localparam logic [7:0]       ADDR_LB_CTRL   = 8'h44;
	localparam logic [7:0]       ADDR_FCS_COUNT = 8'h46;
	localparam logic [7:0]       ADDR_TO_COUNT  = 8'h47;
	// Writing this value to the loopback control register clears both counters.
	localparam logic [REG_W-1:0] CLEAR_VALUE    = 8'h00;
	// Reset values.
	localparam logic [REG_W-1:0] COUNT_RESET    = 8'h00;
	localparam logic [REG_W-1:0] CTRL_RESET     = 8'h00;
	// Read data returned for addresses this block does not own.
	localparam logic [REG_W-1:0] UNMAPPED_READ  = 8'h00;
endpackage
`default_nettype wire

// file: verilog/lbc_sat_counter.sv
`timescale 1ns/10ps
`default_nettype none
module lbc_sat_counter #(
	parameter int unsigned WIDTH = lbc_pkg::REG_W
) (
	input  wire logic             clk_sys_i, // System clock.
	input  wire logic             rstn_i,    // Synchronous reset, active low.
	input  wire logic             clear_i,   // Clear strobe, one cycle.
	input  wire logic             event_i,   // Count strobe, one cycle.
	output logic [WIDTH-1:0]      count_o    // Current count.
);
	localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] ONE      = {{(WIDTH-1){1'b0}}, 1'b1};
	localparam logic [WIDTH-1:0] ZERO     = {WIDTH{1'b0}};

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	wire              at_max = (count_r == ALL_ONES);

	// An event landing in the clear cycle still counts, so it is never lost.
	assign count_nxt = clear_i ? (event_i ? ONE : ZERO)
	                 : (event_i && !at_max) ? count_r + ONE
	                 : count_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			count_r <= ZERO;
		else
			count_r <= count_nxt;
	end

	assign count_o = count_r;
endmodule
`default_nettype wire

// file: verilog/lbc_loopback_result_counters.sv
`timescale 1ns/10ps
`default_nettype none
module lbc_loopback_result_counters #(
	parameter int unsigned WIDTH = lbc_pkg::REG_W
) (
	input  wire logic             clk_sys_i,         // System clock, 100 MHz.
	input  wire logic             rstn_i,            // Synchronous reset, active low.
	input  wire logic [7:0]       reg_addr_i,        // Management register address.
	input  wire logic             reg_wr_i,          // Write strobe, one cycle.
	input  wire logic [WIDTH-1:0] reg_wdata_i,       // Write data.
	input  wire logic             reg_rd_i,          // Read strobe, one cycle.
	output logic [WIDTH-1:0]      reg_rdata_o,       // Read data, registered.
	output logic                  reg_rvalid_o,      // Read data valid, one cycle.
	input  wire logic             timeout_evt_i,     // Loopback packet timed out.
	input  wire logic             fcs_error_evt_i,   // Returned packet had FCS error.
	output logic [WIDTH-1:0]      lb_ctrl_o,         // Loopback control register value.
	output logic [WIDTH-1:0]      timeout_count_o,   // Timeout counter value.
	output logic [WIDTH-1:0]      fcs_error_count_o  // FCS error counter value.
);
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		addr_hit = (addr == target);
	endfunction

	logic [WIDTH-1:0] lb_ctrl_r;
	logic [WIDTH-1:0] rdata_r;
	logic [WIDTH-1:0] rdata_nxt;
	logic             rvalid_r;
	logic [WIDTH-1:0] to_count;
	logic [WIDTH-1:0] fcs_count;

	wire hit_ctrl  = addr_hit(reg_addr_i, lbc_pkg::ADDR_LB_CTRL);
	wire hit_fcs   = addr_hit(reg_addr_i, lbc_pkg::ADDR_FCS_COUNT);
	wire hit_to    = addr_hit(reg_addr_i, lbc_pkg::ADDR_TO_COUNT);
	wire ctrl_wr   = reg_wr_i && hit_ctrl;
	// Only a write of zero clears; any other control value leaves the counts alone.
	wire cnt_clear = ctrl_wr && (reg_wdata_i == lbc_pkg::CLEAR_VALUE);

	// Counter addresses have no write path at all, so writes there are dropped.
	assign rdata_nxt = hit_to   ? to_count
	                 : hit_fcs  ? fcs_count
	                 : hit_ctrl ? lb_ctrl_r
	                 : lbc_pkg::UNMAPPED_READ;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			lb_ctrl_r <= lbc_pkg::CTRL_RESET;
			rdata_r   <= lbc_pkg::COUNT_RESET;
			rvalid_r  <= 1'b0;
		end
		else
		begin
			if (ctrl_wr)
				lb_ctrl_r <= reg_wdata_i;
			if (reg_rd_i)
				rdata_r <= rdata_nxt;
			rvalid_r <= reg_rd_i;
		end
	end

	lbc_sat_counter #(
		.WIDTH     (WIDTH)
	) u_timeout_count (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.clear_i   (cnt_clear),
		.event_i   (timeout_evt_i),
		.count_o   (to_count)
	);

	lbc_sat_counter #(
		.WIDTH     (WIDTH)
	) u_fcs_error_count (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.clear_i   (cnt_clear),
		.event_i   (fcs_error_evt_i),
		.count_o   (fcs_count)
	);

	assign reg_rdata_o       = rdata_r;
	assign reg_rvalid_o      = rvalid_r;
	assign lb_ctrl_o         = lb_ctrl_r;
	assign timeout_count_o   = to_count;
	assign fcs_error_count_o = fcs_count;

	localparam logic [WIDTH-1:0] A_MAX = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] A_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

	property p_timeout_incr;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(timeout_evt_i && !cnt_clear && to_count != A_MAX)
			|=> (to_count == $past(to_count) + A_ONE);
	endproperty
	a_timeout_incr: assert property (p_timeout_incr)
		else $error("Timeout counter did not advance on a timeout event.");

	property p_timeout_read;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(reg_rd_i && hit_to) |=> (reg_rvalid_o && reg_rdata_o == $past(to_count));
	endproperty
	a_timeout_read: assert property (p_timeout_read)
		else $error("Timeout counter read returned the wrong value.");

	property p_fcs_read;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(reg_rd_i && hit_fcs) |=> (reg_rvalid_o && reg_rdata_o == $past(fcs_count));
	endproperty
	a_fcs_read: assert property (p_fcs_read)
		else $error("FCS error counter read returned the wrong value.");

	property p_fcs_clear;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(reg_wr_i && reg_addr_i == lbc_pkg::ADDR_LB_CTRL
			&& reg_wdata_i == lbc_pkg::CLEAR_VALUE)
			|=> (fcs_count == ($past(fcs_error_evt_i) ? A_ONE : lbc_pkg::COUNT_RESET));
	endproperty
	a_fcs_clear: assert property (p_fcs_clear)
		else $error("FCS error counter not cleared by a zero control write.");

	property p_timeout_clear;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(cnt_clear && !timeout_evt_i) |=> (to_count == lbc_pkg::COUNT_RESET);
	endproperty
	a_timeout_clear: assert property (p_timeout_clear)
		else $error("Timeout counter not cleared by a zero control write.");

	property p_timeout_hold;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!timeout_evt_i && !cnt_clear) |=> $stable(to_count);
	endproperty
	a_timeout_hold: assert property (p_timeout_hold)
		else $error("Timeout counter changed without an event or clear.");

	property p_fcs_incr;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(fcs_error_evt_i && !cnt_clear && fcs_count != A_MAX)
			|=> (fcs_count == $past(fcs_count) + A_ONE);
	endproperty
	a_fcs_incr: assert property (p_fcs_incr)
		else $error("FCS error counter did not advance on an error event.");

	property p_saturate;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!cnt_clear && to_count == A_MAX && fcs_count == A_MAX)
			|=> (to_count == A_MAX && fcs_count == A_MAX);
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("A counter wrapped past its maximum.");

	property p_count_write_ignored;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(reg_wr_i && (hit_to || hit_fcs) && !timeout_evt_i && !fcs_error_evt_i)
			|=> ($stable(to_count) && $stable(fcs_count));
	endproperty
	a_count_write_ignored: assert property (p_count_write_ignored)
		else $error("A write to a counter address changed a counter.");

	property p_reset_zero;
		@(posedge clk_sys_i)
		!rstn_i |=> (to_count == lbc_pkg::COUNT_RESET && fcs_count == lbc_pkg::COUNT_RESET);
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("Counters not zero after reset.");

	property p_fcs_hold;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!fcs_error_evt_i && !cnt_clear) |=> $stable(fcs_count);
	endproperty
	a_fcs_hold: assert property (p_fcs_hold)
		else $error("FCS error counter changed without an event or clear.");

	property p_timeout_sat;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(timeout_evt_i && !cnt_clear && to_count == A_MAX) |=> (to_count == A_MAX);
	endproperty
	a_timeout_sat: assert property (p_timeout_sat)
		else $error("Timeout counter wrapped past its maximum.");

	property p_fcs_sat;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(fcs_error_evt_i && !cnt_clear && fcs_count == A_MAX) |=> (fcs_count == A_MAX);
	endproperty
	a_fcs_sat: assert property (p_fcs_sat)
		else $error("FCS error counter wrapped past its maximum.");

	property p_timeout_clear_evt;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(cnt_clear && timeout_evt_i) |=> (to_count == A_ONE);
	endproperty
	a_timeout_clear_evt: assert property (p_timeout_clear_evt)
		else $error("Timeout event lost when it met a clear.");

	property p_ctrl_keep;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(ctrl_wr && reg_wdata_i != lbc_pkg::CLEAR_VALUE && !fcs_error_evt_i)
			|=> $stable(fcs_count);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep)
		else $error("A nonzero control write changed the FCS error counter.");

	property p_ctrl_read;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(reg_rd_i && hit_ctrl) |=> (reg_rvalid_o && reg_rdata_o == $past(lb_ctrl_r));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("Control register read returned the wrong value.");

	property p_rvalid_pulse;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		!reg_rd_i |=> !reg_rvalid_o;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse)
		else $error("Read valid raised without a read strobe.");
endmodule
`default_nettype wire

// file: verif/lbc_loopback_result_counters_test.sv
`timescale 1ns/10ps
`default_nettype none
module lbc_loopback_result_counters_test;
	logic       clk_sys_i;
	logic       rstn_i;
	logic [7:0] reg_addr_i;
	logic       reg_wr_i;
	logic [7:0] reg_wdata_i;
	logic       reg_rd_i;
	logic       timeout_evt_i;
	logic       fcs_error_evt_i;
	logic [7:0] reg_rdata_o;
	logic       reg_rvalid_o;
	logic [7:0] lb_ctrl_o;
	logic [7:0] timeout_count_o;
	logic [7:0] fcs_error_count_o;
	int         err_total;
	int         checks;

	lbc_loopback_result_counters #(.WIDTH(8)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.timeout_evt_i(timeout_evt_i), .fcs_error_evt_i(fcs_error_evt_i),
		.lb_ctrl_o(lb_ctrl_o), .timeout_count_o(timeout_count_o),
		.fcs_error_count_o(fcs_error_count_o));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic close_out;
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// All bus and event tasks start and end at a falling edge.
	// Each ends with one idle cycle, so a strobe never toggles twice in one step.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
		chk({7'h00, reg_rvalid_o}, 8'h01);
		chk(reg_rdata_o, exp);
		@(negedge clk_sys_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
		@(negedge clk_sys_i);
	endtask

	// Events are sent back to back, one per cycle, to catch lost pulses.
	task automatic evt(input logic t, input logic f, input int n);
		repeat (n)
		begin
			timeout_evt_i = t;
			fcs_error_evt_i = f;
			@(negedge clk_sys_i);
		end
		timeout_evt_i = 1'b0;
		fcs_error_evt_i = 1'b0;
		@(negedge clk_sys_i);
	endtask

	task automatic t_reset;
		chk(timeout_count_o, 8'h00);
		chk(fcs_error_count_o, 8'h00);
		rd(8'h47, 8'h00);
		rd(8'h46, 8'h00);
		rd(8'h44, 8'h00);
		chk({7'h00, reg_rvalid_o}, 8'h00);
	endtask

	task automatic t_count;
		evt(1'b1, 1'b0, 3);
		chk(timeout_count_o, 8'h03);
		chk(fcs_error_count_o, 8'h00);
		evt(1'b1, 1'b1, 2);
		chk(timeout_count_o, 8'h05);
		chk(fcs_error_count_o, 8'h02);
		rd(8'h47, 8'h05);
		rd(8'h46, 8'h02);
	endtask

	task automatic t_hold;
		wr(8'h44, 8'h5a);
		wr(8'h47, 8'h00);
		wr(8'h46, 8'h00);
		chk(lb_ctrl_o, 8'h5a);
		chk(timeout_count_o, 8'h05);
		chk(fcs_error_count_o, 8'h02);
		rd(8'h44, 8'h5a);
		rd(8'h10, 8'h00);
	endtask

	task automatic t_clear;
		wr(8'h44, 8'h00);
		chk(timeout_count_o, 8'h00);
		chk(fcs_error_count_o, 8'h00);
		chk(lb_ctrl_o, 8'h00);
	endtask

	task automatic t_sat;
		evt(1'b1, 1'b1, 260);
		chk(timeout_count_o, 8'hff);
		rd(8'h47, 8'hff);
		rd(8'h46, 8'hff);
		// A clear racing both events: the new events must survive.
		timeout_evt_i = 1'b1;
		fcs_error_evt_i = 1'b1;
		reg_wr_i = 1'b1;
		reg_addr_i = 8'h44;
		reg_wdata_i = 8'h00;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
		timeout_evt_i = 1'b0;
		fcs_error_evt_i = 1'b0;
		chk(timeout_count_o, 8'h01);
		chk(fcs_error_count_o, 8'h01);
		@(negedge clk_sys_i);
	endtask

	task automatic t_rerst;
		wr(8'h44, 8'h33);
		evt(1'b1, 1'b1, 2);
		chk(timeout_count_o, 8'h03);
		chk(fcs_error_count_o, 8'h03);
		rstn_i = 1'b0;
		@(negedge clk_sys_i);
		rstn_i = 1'b1;
		chk(timeout_count_o, 8'h00);
		chk(fcs_error_count_o, 8'h00);
		chk(lb_ctrl_o, 8'h00);
		rd(8'h47, 8'h00);
	endtask

	initial
	begin
		err_total = 0;
		checks = 0;
		rstn_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_wdata_i = 8'h00;
		reg_rd_i = 1'b0;
		timeout_evt_i = 1'b0;
		fcs_error_evt_i = 1'b0;
		repeat (20) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		t_reset();
		t_count();
		t_hold();
		t_clear();
		t_sat();
		t_rerst();
		close_out();
	end

	// The run needs about 325 cycles; 3000 leaves ample margin.
	initial
	begin
		repeat (3000) @(posedge clk_sys_i);
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire
